// *** commanded_input_cell.sv ***
`timescale 1ns/10ps
// One commanded binary input with latching and pulse modes
module commanded_input_cell #(
	parameter int PULSE_CYCLES = sig_bank_pkg::PULSE_CYCLES,
	parameter int CNT_W        = sig_bank_pkg::CNT_W
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic mode,
	input  wire logic cmd_set,
	input  wire logic cmd_clear,
	output logic      value
);
	initial begin
		if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << CNT_W))
			$error("commanded_input_cell pulse count does not fit counter");
	end

	logic [CNT_W-1:0] cnt_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			value <= 1'b0;
			cnt_r <= '0;
		end else if (cmd_clear) begin
			value <= 1'b0;
			cnt_r <= '0;
		end else if (cmd_set) begin
			value <= 1'b1;
			cnt_r <= CNT_W'(PULSE_CYCLES - 1);
		end else if (mode == sig_bank_pkg::MODE_PULSE && value) begin
			if (cnt_r == '0)
				value <= 1'b0;
			else
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule // commanded_input_cell

// *** edge_event_scan.sv ***
`timescale 1ns/10ps
// Change detector and event emitter for one group of binary signals
module edge_event_scan #(
	parameter int N       = 32,
	parameter int STAMP_W = 48
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [N-1:0]          sig,
	input  wire logic [1:0]            ev_select,
	input  wire logic [STAMP_W-1:0]    timestamp,
	input  wire logic                  ev_ready,
	output logic                       ev_valid,
	output logic [$clog2(N)-1:0]       ev_index,
	output logic                       ev_on,
	output logic [STAMP_W-1:0]         ev_stamp
);
	localparam int IW = $clog2(N);

	initial begin
		if (N < 2)
			$error("edge_event_scan needs at least two signals");
	end

	logic [N-1:0]         prev_r;
	logic [N-1:0]         pend_r;
	logic [N-1:0]         lvl_r;
	logic [STAMP_W-1:0]   stamp_r [N];
	logic [N-1:0]         chg;
	logic [N-1:0]         want;
	logic [IW-1:0]        pick;
	logic                 any;
	logic                 take;
	logic                 load;

	assign chg  = sig ^ prev_r;
	assign take = ev_valid & ev_ready;
	// A slot frees as its event moves to the output register, so a change that
	// arrives while the older event still waits is queued rather than lost
	assign load = any & (~ev_valid | ev_ready);

	// Filter by direction before queueing so unwanted edges cost no slot
	always_comb begin
		for (int i = 0; i < N; i++) begin
			unique case (sig_bank_pkg::evsel_e'(ev_select))
				sig_bank_pkg::EVSEL_RISING:  want[i] = chg[i] & sig[i];
				sig_bank_pkg::EVSEL_FALLING: want[i] = chg[i] & ~sig[i];
				default:                     want[i] = chg[i];
			endcase
		end
	end

	always_comb begin
		pick = '0;
		any  = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (pend_r[i]) begin
				pick = IW'(i);
				any  = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			prev_r <= '0;
		else
			prev_r <= sig;
	end

	// One pending slot per signal; a newer change overwrites level and stamp
	for (genvar g = 0; g < N; g++) begin : g_slot
		always_ff @(posedge clk) begin
			if (rst) begin
				pend_r[g]  <= 1'b0;
				lvl_r[g]   <= 1'b0;
				stamp_r[g] <= '0;
			end else if (want[g]) begin
				pend_r[g]  <= 1'b1;
				lvl_r[g]   <= sig[g];
				stamp_r[g] <= timestamp;
			end else if (load && pick == IW'(g)) begin
				pend_r[g] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ev_valid <= 1'b0;
			ev_index <= '0;
			ev_on    <= 1'b0;
			ev_stamp <= '0;
		end else if (!ev_valid || take) begin
			ev_valid <= any;
			ev_index <= pick;
			ev_on    <= lvl_r[pick];
			ev_stamp <= stamp_r[pick];
		end
	end

endmodule // edge_event_scan

// *** sig_bank_pkg.sv ***
// Constants and types shared by the virtual binary signal bank
// Overview of operation
// - Thirty-two binary outputs driven by user logic, routable onward as sources.
// - Outputs usable for blocking, setting groups, relays and indicator lamps.
// - Current value of every output readable by the supervisory system.
// - Each input or output change raises an on/off event, groups kept separate; a newer change overwrites one still pending for that signal.
// - Per-function setting selects rising only, falling only, or both events.
// - Every recorded event carries a time stamp taken at the change.
// - Thirty-two inputs set or cleared only by operator or supervisory commands.
// - Inputs are volatile: every restart clears them to zero.
// - Commands come from the local panel switch and the supervisory system.
// - Each input has a mode: latching or pulse.
// - Latching: set drives one, held until clear command or restart.
// - Pulse: set drives one, returned to zero automatically after 5 ms.
package sig_bank_pkg;
	localparam int CLK_HZ        = 100_000_000;
	localparam int PULSE_TIME_US = 5_000;
	localparam int PULSE_CYCLES  = (CLK_HZ / 1_000_000) * PULSE_TIME_US;
	localparam int NUM_SIGNALS   = 32;
	localparam int STAMP_W       = 48;
	localparam int CNT_W         = 20;

	localparam logic MODE_LATCH = 1'b0;
	localparam logic MODE_PULSE = 1'b1;

	localparam logic GROUP_OUTPUT = 1'b0;
	localparam logic GROUP_INPUT  = 1'b1;

	typedef enum logic [1:0] {
		EVSEL_BOTH    = 2'b00,
		EVSEL_RISING  = 2'b01,
		EVSEL_FALLING = 2'b10
	} evsel_e;
endpackage

// *** user_logic_model.sv ***
// User logic: event consumer and off-delay stretch of input 0
`timescale 1ns/10ps
module user_logic_model (
	input  wire logic        clk,
	input  wire logic [31:0] ci,
	input  wire logic [30:0] rnd,
	input  wire logic        stall,
	output logic [31:0]      res,
	output logic             rdy
);
	int t_r;
	always_ff @(posedge clk) t_r <= ci[0] ? 30 : (t_r > 0 ? t_r - 1 : 0);
	assign res = {rnd, ci[0] || t_r > 0};
	assign rdy = !stall;
endmodule // user_logic_model

// *** vbsb_assertions.sv ***
// Port-level checks for the signal bank
`timescale 1ns/10ps
module vbsb_checker #(
	parameter int N            = 32,
	parameter int PULSE_CYCLES = 500000
) (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic [N-1:0]         logic_result,
	input wire logic [N-1:0]         input_mode,
	input wire logic [N-1:0]         panel_set,
	input wire logic [N-1:0]         panel_clear,
	input wire logic [N-1:0]         remote_set,
	input wire logic [N-1:0]         remote_clear,
	input wire logic [1:0]           in_ev_select,
	input wire logic                 ev_ready,
	input wire logic [N-1:0]         logic_driven_output_n,
	input wire logic [N-1:0]         commanded_input_n,
	input wire logic                 ev_valid,
	input wire logic                 ev_group,
	input wire logic [$clog2(N)-1:0] ev_index,
	input wire logic                 ev_on
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic set0;
	logic clr0;
	int   hi_r;
	assign set0 = panel_set[0] || remote_set[0];
	assign clr0 = panel_clear[0] || remote_clear[0];
	// Zeroed by every set, since a fresh set restarts the pulse
	always_ff @(posedge clk) hi_r <= (set0 || !commanded_input_n[0]) ? 0 : hi_r + 1;
	sequence in0_rise;
		$rose(commanded_input_n[0]) && in_ev_select != sig_bank_pkg::EVSEL_FALLING;
	endsequence
	sequence in0_event;
		ev_valid && ev_group && ev_index == '0 && ev_on;
	endsequence
	AST_OUT_COPY: assert property (1 |=> logic_driven_output_n == $past(logic_result))
		else $error("output copy wrong");
	AST_SET: assert property (set0 && !clr0 |=> commanded_input_n[0])
		else $error("set not taken");
	AST_CLEAR: assert property (clr0 |=> !commanded_input_n[0])
		else $error("clear not taken");
	AST_HOLD: assert property (commanded_input_n[0] && !input_mode[0] && !clr0 |=> commanded_input_n[0])
		else $error("latch lost");
	AST_PULSE: assert property ($fell(commanded_input_n[0]) && $past(input_mode[0])
		&& !$past(clr0) && !$past(rst) |-> hi_r == PULSE_CYCLES)
		else $error("pulse length wrong");
	AST_EV_HOLD: assert property (ev_valid && !ev_ready |=> ev_valid)
		else $error("event dropped");
	AST_IN_EVENT: assert property (in0_rise |-> ##[1:40] in0_event)
		else $error("input event missing");
	AST_RESET: assert property (disable iff (1'b0) rst |=> commanded_input_n == '0 && !ev_valid)
		else $error("reset not clean");
endmodule // vbsb_checker

// *** virtual_binary_signal_bank.sv ***
`timescale 1ns/10ps
// Bank of commanded binary inputs and logic-driven binary outputs with event reporting
module virtual_binary_signal_bank #(
	parameter int N            = sig_bank_pkg::NUM_SIGNALS,
	parameter int STAMP_W      = sig_bank_pkg::STAMP_W,
	parameter int PULSE_CYCLES = sig_bank_pkg::PULSE_CYCLES
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [N-1:0]          logic_result,
	input  wire logic [N-1:0]          input_mode,
	input  wire logic [N-1:0]          panel_set,
	input  wire logic [N-1:0]          panel_clear,
	input  wire logic [N-1:0]          remote_set,
	input  wire logic [N-1:0]          remote_clear,
	input  wire logic [1:0]            out_ev_select,
	input  wire logic [1:0]            in_ev_select,
	input  wire logic                  ev_ready,
	output logic [N-1:0]               logic_driven_output_n,
	output logic [N-1:0]               remote_output_status,
	output logic [N-1:0]               commanded_input_n,
	output logic [STAMP_W-1:0]         time_now,
	output logic                       ev_valid,
	output logic                       ev_group,
	output logic [$clog2(N)-1:0]       ev_index,
	output logic                       ev_on,
	output logic [STAMP_W-1:0]         ev_stamp
);
	initial begin
		if (N < 2 || N > 32)
			$error("virtual_binary_signal_bank supports 2 to 32 signals");
	end

	logic                  out_valid;
	logic [$clog2(N)-1:0]  out_index;
	logic                  out_on;
	logic [STAMP_W-1:0]    out_stamp;
	logic                  in_valid;
	logic [$clog2(N)-1:0]  in_index;
	logic                  in_on;
	logic [STAMP_W-1:0]    in_stamp;
	logic                  out_sel;

	// Free-running system time in clock cycles
	always_ff @(posedge clk) begin
		if (rst)
			time_now <= '0;
		else
			time_now <= time_now + 1'b1;
	end

	// Outputs registered so relays, lamps and blocking see a clean level
	always_ff @(posedge clk) begin
		if (rst)
			logic_driven_output_n <= '0;
		else
			logic_driven_output_n <= logic_result;
	end

	assign remote_output_status = logic_driven_output_n;

	// Panel and remote commands merge; a clear from either source wins
	for (genvar g = 0; g < N; g++) begin : g_in
		commanded_input_cell #(
			.PULSE_CYCLES (PULSE_CYCLES),
			.CNT_W        (sig_bank_pkg::CNT_W)
		) u_cell (
			.clk       (clk),
			.rst       (rst),
			.mode      (input_mode[g]),
			.cmd_set   (panel_set[g] | remote_set[g]),
			.cmd_clear (panel_clear[g] | remote_clear[g]),
			.value     (commanded_input_n[g])
		);
	end

	edge_event_scan #(.N(N), .STAMP_W(STAMP_W)) u_out_ev (
		.clk       (clk),
		.rst       (rst),
		.sig       (logic_driven_output_n),
		.ev_select (out_ev_select),
		.timestamp (time_now),
		.ev_ready  (ev_ready & out_sel),
		.ev_valid  (out_valid),
		.ev_index  (out_index),
		.ev_on     (out_on),
		.ev_stamp  (out_stamp)
	);

	edge_event_scan #(.N(N), .STAMP_W(STAMP_W)) u_in_ev (
		.clk       (clk),
		.rst       (rst),
		.sig       (commanded_input_n),
		.ev_select (in_ev_select),
		.timestamp (time_now),
		.ev_ready  (ev_ready & ~out_sel),
		.ev_valid  (in_valid),
		.ev_index  (in_index),
		.ev_on     (in_on),
		.ev_stamp  (in_stamp)
	);

	// Output group has fixed priority; inputs wait while outputs stream
	assign out_sel  = out_valid;
	assign ev_valid = out_valid | in_valid;
	assign ev_group = out_sel ? sig_bank_pkg::GROUP_OUTPUT : sig_bank_pkg::GROUP_INPUT;
	assign ev_index = out_sel ? out_index : in_index;
	assign ev_on    = out_sel ? out_on : in_on;
	assign ev_stamp = out_sel ? out_stamp : in_stamp;
endmodule // virtual_binary_signal_bank

// *** virtual_binary_signal_bank_tb.sv ***
// Self-checking bench for the signal bank
`timescale 1ns/10ps
module virtual_binary_signal_bank_tb;
	localparam int P = 20;
	logic        clk = 0, rst = 1, stall = 0, rdy, ev_valid, ev_group, ev_on, found;
	logic [31:0] mode = 0, ps = 0, pc = 0, rs = 0, rc = 0, seed = 32'h1E, res, ldo, ros, cin, prev;
	logic [30:0] rnd = 0;
	logic [1:0]  sel = 0;
	logic [4:0]  ev_index;
	logic [47:0] tnow, stamp;
	longint      cyc = 0, t_chg = 0;
	int          bad_count = 0, checks = 0, n;
	virtual_binary_signal_bank #(.PULSE_CYCLES(P)) u_virtual_binary_signal_bank (.clk, .rst,
		.logic_result(res), .input_mode(mode), .panel_set(ps), .panel_clear(pc),
		.remote_set(rs), .remote_clear(rc), .out_ev_select(sel), .in_ev_select(sel),
		.ev_ready(rdy), .logic_driven_output_n(ldo), .remote_output_status(ros),
		.commanded_input_n(cin), .time_now(tnow), .ev_valid, .ev_group, .ev_index, .ev_on,
		.ev_stamp(stamp));
	user_logic_model u_user_logic_model (.clk, .ci(cin), .rnd, .stall, .res, .rdy);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic want(input logic [1:0] s, input logic on);
		return on ? s != sig_bank_pkg::EVSEL_FALLING : s != sig_bank_pkg::EVSEL_RISING;
	endfunction
	task automatic chk(input logic [63:0] exp, got, input string what);
		checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
			bad_count++;
		end
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic tick;
		@(posedge clk);
		cyc = rst ? 0 : cyc + 1;
		#1;
		seed = lfsr(seed);
		stall = seed[0];
	endtask
	// k holds remote clear, remote set, panel clear, panel set
	task automatic cmd(input int b, input logic [3:0] k);
		tick;
		{rc[b], rs[b], pc[b], ps[b]} = k;
		tick;
		t_chg = cyc;
		{rc[b], rs[b], pc[b], ps[b]} = 4'h0;
	endtask
	// Other events are taken and skipped
	task automatic wait_ev(input logic on);
		found = 0;
		for (n = 0; n < 60 && !found; n++) begin
			tick;
			if (ev_valid === 1'b1 && !stall && ev_group === 1'b1 && ev_index === 5'h00) begin
				found = 1;
				chk(on, ev_on, "ev_on");
				chk(t_chg, stamp, "ev_stamp");
			end
		end
	endtask
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (12) tick;
		rst = 0;
		chk(0, cin, "reset");
		for (int i = 0; i < 200; i++) begin
			rnd = seed[31:1];
			sel = seed[3:2];
			#1 prev = res;
			tick;
			chk(prev, ldo, "output");
			chk(prev, ros, "readback");
		end
		// Random outputs leave a queue of output events; let it empty first
		for (n = 0; n < 300 && (n < 3 || ev_valid !== 1'b0); n++) tick;
		chk(0, ev_valid, "drain");
		chk(cyc, tnow, "time_now");
		for (int s = 0; s < 4; s++) begin
			sel = s[1:0];
			cmd(0, 4'h4);
			chk(1, cin[0], "set");
			wait_ev(1);
			chk(want(sel, 1), found, "on event");
			cmd(0, 4'h1);
			wait_ev(1);
			chk(0, found, "repeat event");
			cmd(0, 4'h2);
			chk(0, cin[0], "clear");
			wait_ev(0);
			chk(want(sel, 0), found, "off event");
		end
		cmd(9, 4'h9);
		chk(0, cin[9], "clear beats set");
		mode[0] = 1;
		cmd(0, 4'h1);
		for (n = 0; n < 100 && cin[0] === 1'b1; n++) tick;
		chk(P, n, "pulse");
		if (n == 100) end_of_test;
		cmd(3, 4'h4);
		chk(1, cin[3], "set before restart");
		rst = 1;
		repeat (2) tick;
		rst = 0;
		chk(0, cin, "restart");
		chk(0, ev_valid, "restart events");
		ps[5] = 1;
		tick;
		ps[5] = 0;
		chk(1, cin[5], "set after restart");
		end_of_test;
	end
endmodule // virtual_binary_signal_bank_tb
bind virtual_binary_signal_bank vbsb_checker #(.N(N), .PULSE_CYCLES(PULSE_CYCLES)) u_vbsb_checker
	(.clk, .rst, .logic_result, .input_mode, .panel_set, .panel_clear, .remote_set,
	.remote_clear, .in_ev_select, .ev_ready, .logic_driven_output_n, .commanded_input_n,
	.ev_valid, .ev_group, .ev_index, .ev_on);
